// *** lsd_line_state.sv ***
// Our own choices: the APB interface to the registers and the placing of the registers.
`include "lsd_params.svh"
// Functional notes
// - dead output only when all voltages and all currents below thresholds
// - live output when all three voltages exceed threshold, currents ignored
// - one voltage-above flag per phase
// - one current-above flag per phase
// - on/off operation setting, default on; off disables detection
// - voltage threshold 10 to 100 percent, 1 percent steps, default 60
// - current threshold 8 to 100 percent, 1 percent steps, default 10
module lsd_line_state
  import lsd_pkg::*;
#(
  parameter int MAG_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measurement front end
  input wire logic [MAG_W-1:0] voltRated,
  input wire logic [MAG_W-1:0] currRated,
  input wire logic [MAG_W-1:0] voltPh1,
  input wire logic [MAG_W-1:0] voltPh2,
  input wire logic [MAG_W-1:0] voltPh3,
  input wire logic [MAG_W-1:0] currPh1,
  input wire logic [MAG_W-1:0] currPh2,
  input wire logic [MAG_W-1:0] currPh3,
  input wire logic detectBlockIn,
  // line state outputs
  output logic voltAbovePh1,
  output logic voltAbovePh2,
  output logic voltAbovePh3,
  output logic currAbovePh1,
  output logic currAbovePh2,
  output logic currAbovePh3,
  output logic lineDeadOut,
  output logic lineLiveOut
);
  // products must stay within a 31-bit compare
  if (MAG_W < 2 || MAG_W > 24) begin : g_bad_width
    $error("lsd_line_state: MAG_W out of range");
  end

  // ---------------------------------------------
  // register file
  // ---------------------------------------------
  lsd_op_t opMode_r;
  lsd_pct_t voltThr_r;
  lsd_pct_t currThr_r;
  logic wrEn;
  logic rdEn;
  logic [31:0] rdData;
  logic addrOk;

  // clamp a written percentage into its legal range
  function automatic lsd_pct_t clampPct(input logic [31:0] v, input lsd_pct_t lo,
                                        input lsd_pct_t hi);
    if (v < 32'(lo)) clampPct = lo;
    else if (v > 32'(hi)) clampPct = hi;
    else clampPct = v[6:0];
  endfunction

  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign addrOk = (paddr == `LSD_CTRL_OFF) || (paddr == `LSD_VTHR_OFF) ||
                  (paddr == `LSD_ITHR_OFF) || (paddr == `LSD_STAT_OFF);
  assign pslverr = psel && penable && !addrOk;

  // operation on/off setting
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opMode_r <= LSD_ON;
    end else if (wrEn && paddr == `LSD_CTRL_OFF) begin
      opMode_r <= pwdata[`LSD_CTRL_ON_BIT] ? LSD_ON : LSD_OFF;
    end
  end

  // voltage threshold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      voltThr_r <= `LSD_VTHR_RST;
    end else if (wrEn && paddr == `LSD_VTHR_OFF) begin
      voltThr_r <= clampPct(pwdata, `LSD_VTHR_MIN, `LSD_VTHR_MAX);
    end
  end

  // current threshold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      currThr_r <= `LSD_ITHR_RST;
    end else if (wrEn && paddr == `LSD_ITHR_OFF) begin
      currThr_r <= clampPct(pwdata, `LSD_ITHR_MIN, `LSD_ITHR_MAX);
    end
  end

  // read mux
  always_comb begin
    rdData = 32'h00000000;
    case (paddr)
      `LSD_CTRL_OFF: rdData = {31'h0, opMode_r == LSD_ON};
      `LSD_VTHR_OFF: rdData = {25'h0, voltThr_r};
      `LSD_ITHR_OFF: rdData = {25'h0, currThr_r};
      `LSD_STAT_OFF: rdData = {24'h0, lineLiveOut, lineDeadOut, currAbovePh3, currAbovePh2,
                               currAbovePh1, voltAbovePh3, voltAbovePh2, voltAbovePh1};
      default: rdData = 32'h00000000;
    endcase
  end

  // registered read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdData;
    end
  end

  // ---------------------------------------------
  // comparators
  // ---------------------------------------------
  logic [MAG_W-1:0] mags [6];
  logic [MAG_W-1:0] rateds [6];
  lsd_pct_t pcts [6];
  logic [5:0] rawAbove;

  assign mags[0] = voltPh1;
  assign mags[1] = voltPh2;
  assign mags[2] = voltPh3;
  assign mags[3] = currPh1;
  assign mags[4] = currPh2;
  assign mags[5] = currPh3;

  for (genvar g = 0; g < 6; g++) begin : g_cmp
    assign rateds[g] = (g < 3) ? voltRated : currRated;
    assign pcts[g] = (g < 3) ? voltThr_r : currThr_r;
    lsd_phase_cmp #(.MAG_W(MAG_W)) u_cmp (
      .clk(clk),
      .rst(rst),
      .mag(mags[g]),
      .rated(rateds[g]),
      .pct(pcts[g]),
      .above(rawAbove[g])
    );
  end

  // ---------------------------------------------
  // line state decision
  // ---------------------------------------------
  logic active;
  logic [MAG_W+6:0] vLhs [3];
  logic [MAG_W+6:0] vRhs;
  logic [MAG_W+6:0] iLhs [3];
  logic [MAG_W+6:0] iRhs;
  logic allVBelow;
  logic allIBelow;
  logic deadRaw_r;

  assign active = (opMode_r == LSD_ON) && !detectBlockIn;

  // strict below tests, separate from the above tests so equality counts as neither
  assign vRhs = (MAG_W+7)'(voltRated) * (MAG_W+7)'(voltThr_r);
  assign iRhs = (MAG_W+7)'(currRated) * (MAG_W+7)'(currThr_r);
  for (genvar p = 0; p < 3; p++) begin : g_below
    assign vLhs[p] = (MAG_W+7)'(mags[p]) * (MAG_W+7)'(`LSD_PCT_FULL);
    assign iLhs[p] = (MAG_W+7)'(mags[p+3]) * (MAG_W+7)'(`LSD_PCT_FULL);
  end
  assign allVBelow = (vLhs[0] < vRhs) && (vLhs[1] < vRhs) && (vLhs[2] < vRhs);
  assign allIBelow = (iLhs[0] < iRhs) && (iLhs[1] < iRhs) && (iLhs[2] < iRhs);

  // per-phase flags gated by enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {currAbovePh3, currAbovePh2, currAbovePh1} <= 3'h0;
      {voltAbovePh3, voltAbovePh2, voltAbovePh1} <= 3'h0;
    end else begin
      {voltAbovePh3, voltAbovePh2, voltAbovePh1} <= active ? rawAbove[2:0] : 3'h0;
      {currAbovePh3, currAbovePh2, currAbovePh1} <= active ? rawAbove[5:3] : 3'h0;
    end
  end

  // below stage, keeps dead in step with the comparator flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      deadRaw_r <= 1'b0;
    end else begin
      deadRaw_r <= allVBelow && allIBelow;
    end
  end

  // dead and live conditions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lineDeadOut <= 1'b0;
      lineLiveOut <= 1'b0;
    end else begin
      lineDeadOut <= active && deadRaw_r;
      lineLiveOut <= active && (&rawAbove[2:0]);
    end
  end

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  sequence blockedSeq;
    !active;
  endsequence
  property outsLowAfterBlock;
    @(posedge clk) disable iff (rst)
      blockedSeq ##1 blockedSeq |-> !lineDeadOut && !lineLiveOut &&
        !voltAbovePh1 && !currAbovePh1;
  endproperty
  outs_quiet_a: assert property (outsLowAfterBlock) else $error("outputs not held low");
  dead_live_excl_a: assert property (@(posedge clk) disable iff (rst)
    !(lineDeadOut && lineLiveOut)) else $error("dead and live together");
  dead_cause_a: assert property (@(posedge clk) disable iff (rst)
    lineDeadOut |-> !voltAbovePh1 && !voltAbovePh2 && !voltAbovePh3 && !currAbovePh1 &&
      !currAbovePh2 && !currAbovePh3) else $error("dead with a phase above");
  live_cause_a: assert property (@(posedge clk) disable iff (rst)
    lineLiveOut == (voltAbovePh1 && voltAbovePh2 && voltAbovePh3))
    else $error("live mismatch with voltage flags");
  volt_flag_a: assert property (@(posedge clk) disable iff (rst)
    $past(active) |-> voltAbovePh1 == $past(rawAbove[0]))
    else $error("voltage flag wrong");
  curr_flag_a: assert property (@(posedge clk) disable iff (rst)
    $past(active) |-> currAbovePh2 == $past(rawAbove[4]))
    else $error("current flag wrong");
  block_kill_a: assert property (@(posedge clk) disable iff (rst)
    detectBlockIn |=> !lineLiveOut && !lineDeadOut) else $error("block ignored");
  op_off_a: assert property (@(posedge clk) disable iff (rst)
    opMode_r == LSD_OFF |=> !lineLiveOut && !currAbovePh3) else $error("off ignored");
  vthr_range_a: assert property (@(posedge clk) disable iff (rst)
    voltThr_r >= `LSD_VTHR_MIN && voltThr_r <= `LSD_VTHR_MAX)
    else $error("voltage threshold out of range");
  ithr_range_a: assert property (@(posedge clk) disable iff (rst)
    currThr_r >= `LSD_ITHR_MIN && currThr_r <= `LSD_ITHR_MAX)
    else $error("current threshold out of range");
  strict_cmp_a: assert property (@(posedge clk) disable iff (rst)
    (vLhs[0] == vRhs) |=> !rawAbove[0]) else $error("equality counted as above");
endmodule

// *** lsd_params.svh ***
`ifndef LSD_PARAMS_SVH
`define LSD_PARAMS_SVH
// register byte offsets
`define LSD_CTRL_OFF 12'h000
`define LSD_VTHR_OFF 12'h004
`define LSD_ITHR_OFF 12'h008
`define LSD_STAT_OFF 12'h00C
// control fields
`define LSD_CTRL_ON_BIT 0
`define LSD_CTRL_RST 32'h00000001
// threshold ranges and defaults in percent
`define LSD_VTHR_MIN 7'h0A
`define LSD_VTHR_MAX 7'h64
`define LSD_VTHR_RST 7'h3C
`define LSD_ITHR_MIN 7'h08
`define LSD_ITHR_MAX 7'h64
`define LSD_ITHR_RST 7'h0A
// percent scale divisor
`define LSD_PCT_FULL 7'h64
`endif

// *** lsd_pkg.sv ***
package lsd_pkg;
  typedef logic [6:0] lsd_pct_t;
  typedef enum logic {LSD_OFF, LSD_ON} lsd_op_t;
endpackage

// *** lsd_phase_cmp.sv ***
`include "lsd_params.svh"
// ---------------------------------------------
// per-phase threshold comparator
// ---------------------------------------------
module lsd_phase_cmp
  import lsd_pkg::*;
#(
  parameter int MAG_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [MAG_W-1:0] mag,
  input wire logic [MAG_W-1:0] rated,
  input wire lsd_pct_t pct,
  output logic above
);
  // products must stay within a 31-bit compare
  if (MAG_W < 2 || MAG_W > 24) begin : g_bad_width
    $error("lsd_phase_cmp: MAG_W out of range");
  end
  logic [MAG_W+6:0] lhs;
  logic [MAG_W+6:0] rhs;
  // mag*100 > rated*pct, strict compare
  assign lhs = (MAG_W+7)'(mag) * (MAG_W+7)'(`LSD_PCT_FULL);
  assign rhs = (MAG_W+7)'(rated) * (MAG_W+7)'(pct);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      above <= 1'b0;
    end else begin
      above <= (lhs > rhs);
    end
  end
endmodule

// *** lsd_front_end.sv ***
// ---------------------------------------------
// measurement front end model
// ---------------------------------------------
module lsd_front_end #(
  parameter int MAG_W = 16
) (
  input wire logic clk,
  input wire logic [MAG_W-1:0] magSet [6],
  output logic [MAG_W-1:0] magOut [6]
);
  timeunit 1ns;
  timeprecision 1ns;
  // one sample per clock, in step with clk
  always @(posedge clk) magOut <= magSet;
endmodule

// *** lsd_line_state_bench.sv ***
// ---------------------------------------------
// line state bench
// ---------------------------------------------
module lsd_line_state_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RV = 1000;
  localparam int RI = 500;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic detectBlockIn = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic [15:0] magSet [6] = '{default: 16'h0000};
  logic [15:0] mag [6];
  logic [7:0] outs;
  int errorCnt = 0, compares = 0, vthr = 60, ithr = 10, onBit = 1;
  int tbl [6][3] = '{'{4, 9, 10}, '{4, 101, 100}, '{4, 10, 10}, '{8, 7, 8}, '{8, 101, 100},
    '{8, 8, 8}};
  always #50 clk = ~clk;
  lsd_front_end #(.MAG_W(16)) FE (.clk(clk), .magSet(magSet), .magOut(mag));
  lsd_line_state #(.MAG_W(16)) DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .voltRated(16'(RV)), .currRated(16'(RI)), .voltPh1(mag[0]),
    .voltPh2(mag[1]), .voltPh3(mag[2]), .currPh1(mag[3]), .currPh2(mag[4]),
    .currPh3(mag[5]), .detectBlockIn(detectBlockIn), .voltAbovePh1(outs[0]),
    .voltAbovePh2(outs[1]), .voltAbovePh3(outs[2]), .currAbovePh1(outs[3]),
    .currAbovePh2(outs[4]), .currAbovePh3(outs[5]), .lineDeadOut(outs[6]),
    .lineLiveOut(outs[7]));
  // ---------------------------------------------
  // reference model and compares
  // ---------------------------------------------
  function automatic logic [7:0] expOut();
    logic [7:0] e;
    int dv;
    dv = 0;
    for (int k = 0; k < 3; k++) begin
      e[k] = int'(magSet[k]) * 100 > RV * vthr;
      e[k+3] = int'(magSet[k+3]) * 100 > RI * ithr;
      dv += int'(int'(magSet[k]) * 100 < RV * vthr) + int'(int'(magSet[k+3]) * 100 < RI * ithr);
    end
    e[6] = dv == 6;
    e[7] = &e[2:0];
    return (onBit == 1 && detectBlockIn === 1'b0) ? e : 8'h00;
  endfunction
  task automatic checkVal(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ---------------------------------------------
  // apb master
  // ---------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [32:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) begin
      errorCnt++;
      $display("BAD at %0t: no pready", $time);
    end
    rd = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrReg(input logic [11:0] a, input int d);
    logic [32:0] rd;
    apb(1'b1, a, 32'(d), rd);
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [32:0] exp);
    logic [32:0] rd;
    apb(1'b0, a, 32'h00000000, rd);
    checkVal(rd, exp);
  endtask
  // magnitudes just under, just over or around each threshold
  function automatic logic [15:0] pick(input int base, input int m);
    int off;
    off = m == 0 ? -1 - int'($urandom % 3) : m == 1 ? 1 + int'($urandom % 3) : int'($urandom % 5) - 2;
    return 16'(base + off);
  endfunction
  task automatic trial(input int vm, input int im);
    @(posedge clk);
    for (int k = 0; k < 6; k++) magSet[k] <= k < 3 ? pick(10 * vthr, vm) : pick(5 * ithr, im);
    repeat (4) @(posedge clk);
    #10;
    checkVal({25'h0, outs}, {25'h0, expOut()});
  endtask
  task automatic stopTest();
    $display("compares %0d mismatches %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ---------------------------------------------
  // test sequence
  // ---------------------------------------------
  initial begin
    void'($urandom(32'h5b42604a));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdChk(12'h000, 33'h000000001);
    rdChk(12'h004, 33'h00000003C);
    rdChk(12'h008, 33'h00000000A);
    rdChk(12'h010, 33'h100000000);
    $display("test reset values done");
    for (int t = 0; t < 6; t++) begin
      wrReg(12'(tbl[t][0]), tbl[t][1]);
      rdChk(12'(tbl[t][0]), 33'(tbl[t][2]));
      if (tbl[t][0] == 4) vthr = tbl[t][2];
      else ithr = tbl[t][2];
      trial(t % 3, (t + 1) % 3);
    end
    $display("test threshold limits done");
    for (int t = 0; t < 30; t++) begin
      vthr = 10 + int'($urandom % 91);
      ithr = 8 + int'($urandom % 93);
      wrReg(12'h004, vthr);
      wrReg(12'h008, ithr);
      trial(int'($urandom % 3), int'($urandom % 3));
      rdChk(12'h00C, {25'h0, expOut()});
    end
    $display("test random lines done");
    wrReg(12'h000, 0);
    onBit = 0;
    trial(1, 0);
    wrReg(12'h000, 1);
    onBit = 1;
    detectBlockIn <= 1'b1;
    trial(1, 0);
    detectBlockIn <= 1'b0;
    trial(1, 0);
    $display("test off and block done");
    stopTest();
  end
  // hang guard, far beyond the expected run
  initial begin
    #3000000;
    errorCnt++;
    $display("BAD at %0t: run timed out", $time);
    stopTest();
  end
endmodule
